/* File: hw/ppio_defines.vh */
`ifndef PPIO_DEFINES_VH
`define PPIO_DEFINES_VH

// Address map on the two address inputs
`define PPIO_ADR_PA 2'h0
`define PPIO_ADR_PB 2'h1
`define PPIO_ADR_PC 2'h2
`define PPIO_ADR_CTL 2'h3

// Control word: bit 7 set selects mode/direction word, clear selects bit set/reset
`define PPIO_CTL_FLAG 7
`define PPIO_CTL_AMODE_HI 6
`define PPIO_CTL_AMODE_LO 5
`define PPIO_CTL_ADIR 4
`define PPIO_CTL_CHDIR 3
`define PPIO_CTL_BMODE 2
`define PPIO_CTL_BDIR 1
`define PPIO_CTL_CLDIR 0
`define PPIO_BSR_SEL_HI 3
`define PPIO_BSR_SEL_LO 1
`define PPIO_BSR_VAL 0

// Reset value: every port input, group modes basic
`define PPIO_CTL_RESET 8'h9B

// Group modes
`define PPIO_MODE_BASIC 2'h0
`define PPIO_MODE_STROBE 2'h1
`define PPIO_MODE_BIDIR 2'h2

// Third-port handshake bit positions
`define PPIO_PC_INTRB 0
`define PPIO_PC_IBFB 1
`define PPIO_PC_STBB 2
`define PPIO_PC_INTRA 3
`define PPIO_PC_STBA 4
`define PPIO_PC_IBFA 5
`define PPIO_PC_ACKA 6
`define PPIO_PC_OBFA 7
// In strobed output mode for the first port the handshake moves
`define PPIO_PC_ACKA_OUT 6
`define PPIO_PC_OBFA_OUT 7

`endif

/* File: hw/ppio_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pin inputs
module ppio_sync #(
   parameter WIDTH = 8
) (
   input wire sys_clk_i,             // System clock
   input wire ce_i,                  // Clock enable
   input wire [WIDTH-1:0] async_i,   // Asynchronous level
   output reg [WIDTH-1:0] sync_o     // Synchronised level
);
   reg [WIDTH-1:0] stage;

   always @(posedge sys_clk_i) begin
      if (ce_i) begin
         stage <= async_i;
         sync_o <= stage;
      end
   end
endmodule
`default_nettype wire

/* File: hw/ppio_hs.v */
`timescale 1ns/1ps
`default_nettype none
// Strobed handshake for one port: input latch or output buffer-full
module ppio_hs #(
   parameter WIDTH = 8
) (
   input wire sys_clk_i,             // System clock
   input wire rst_n_i,               // Synchronous reset, active low
   input wire ce_i,                  // Clock enable
   input wire active_i,              // Port in strobed mode
   input wire in_dir_i,              // Port direction is input
   input wire inte_i,                // Interrupt enable
   input wire stb_n_i,               // Input strobe, synchronised
   input wire ack_n_i,               // Output acknowledge, synchronised
   input wire [WIDTH-1:0] pins_i,    // Synchronised port pins
   input wire cpu_rd_i,              // Host read of this port
   input wire cpu_wr_i,              // Host write of this port
   output reg [WIDTH-1:0] latch_o,   // Latched input data
   output reg ibf_o,                 // Input buffer full
   output reg obf_n_o,               // Output buffer full, active low
   output reg intr_o                 // Interrupt request
);
   reg stb_d;
   reg ack_d;
   wire stb_fall;
   wire stb_rise;
   wire ack_rise;

   assign stb_fall = stb_d & ~stb_n_i;
   assign stb_rise = ~stb_d & stb_n_i;
   assign ack_rise = ~ack_d & ack_n_i;

   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         stb_d <= 1'b1;
         ack_d <= 1'b1;
         latch_o <= {WIDTH{1'b0}};
         ibf_o <= 1'b0;
         obf_n_o <= 1'b1;
         intr_o <= 1'b0;
      end else if (ce_i) begin
         stb_d <= stb_n_i;
         ack_d <= ack_n_i;
         if (!active_i) begin
            ibf_o <= 1'b0;
            obf_n_o <= 1'b1;
            intr_o <= 1'b0;
         end else if (in_dir_i) begin
            obf_n_o <= 1'b1;
            if (stb_fall) begin
               latch_o <= pins_i;
            end
            // Strobe edge wins over a concurrent host read
            if (stb_fall) begin
               ibf_o <= 1'b1;
            end else if (cpu_rd_i) begin
               ibf_o <= 1'b0;
            end
            if (stb_rise && inte_i && (ibf_o || stb_fall)) begin
               intr_o <= 1'b1;
            end else if (cpu_rd_i) begin
               intr_o <= 1'b0;
            end
         end else begin
            ibf_o <= 1'b0;
            if (cpu_wr_i) begin
               obf_n_o <= 1'b0;
            end else if (!ack_n_i) begin
               obf_n_o <= 1'b1;
            end
            if (ack_rise && inte_i && obf_n_o) begin
               intr_o <= 1'b1;
            end else if (cpu_wr_i) begin
               intr_o <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: hw/ppio_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "ppio_defines.vh"

// Behaviour
// - Twenty-four lines form three independent eight-bit ports.
// - The lines form two groups of twelve, each with its own mode.
// - In basic mode each port and each half of the third port has its own direction.
// - Basic outputs are held in registers while basic inputs reach the bus through the pin synchronisers and the bus output register.
// - In strobed mode ports one and two each act as strobed input or output with handshake on port three.
// - In bidirectional mode port one is a two-way bus steered by third-port lines.
// - With port one bidirectional, port two may still run basic or strobed.
// - Reset makes every port an input so no line is driven.
// - A single control write sets or clears one third-port output bit.
// - Host and device talk over an eight-bit two-way bus with select, read and write strobes.
module ppio_top #(
   parameter WIDTH = 8
) (
   input wire SYS_CLK_I,                // System clock, 20 MHz
   input wire RST_N_I,                  // Synchronous reset, active low
   input wire CE_I,                     // Clock enable
   input wire CS_N_I,                   // Chip select, active low
   input wire RD_N_I,                   // Read strobe, active low
   input wire WR_N_I,                   // Write strobe, active low
   input wire [1:0] ADDR_I,             // Register select
   input wire [WIDTH-1:0] DATA_I,       // System data bus in
   output reg [WIDTH-1:0] DATA_O,       // System data bus out
   output reg DATA_OE_O,                // System data bus drive enable
   input wire [WIDTH-1:0] PA_I,         // First port pins in
   output reg [WIDTH-1:0] PA_O,         // First port pins out
   output reg [WIDTH-1:0] PA_OE_O,      // First port drive enables
   input wire [WIDTH-1:0] PB_I,         // Second port pins in
   output reg [WIDTH-1:0] PB_O,         // Second port pins out
   output reg [WIDTH-1:0] PB_OE_O,      // Second port drive enables
   input wire [WIDTH-1:0] PC_I,         // Third port pins in
   output reg [WIDTH-1:0] PC_O,         // Third port pins out
   output reg [WIDTH-1:0] PC_OE_O       // Third port drive enables
);
   reg [WIDTH-1:0] ctl;
   reg [WIDTH-1:0] out_a;
   reg [WIDTH-1:0] out_b;
   reg [WIDTH-1:0] out_c;
   reg [2:0] ctl_sync;
   reg rd_d;
   reg wr_d;
   wire [WIDTH-1:0] pa_s;
   wire [WIDTH-1:0] pb_s;
   wire [WIDTH-1:0] pc_s;
   wire [2:0] strb_s;
   wire cs;
   wire rd_s;
   wire wr_s;
   wire rd_end;
   wire wr_pulse;
   wire [1:0] mode_a;
   wire mode_b;
   wire a_in;
   wire b_in;
   wire ch_in;
   wire cl_in;
   wire a_strobe;
   wire a_bidir;
   wire wr_a;
   wire wr_b;
   wire rd_a;
   wire rd_b;
   wire [WIDTH-1:0] lat_a;
   wire [WIDTH-1:0] lat_b;
   wire ibf_a;
   wire ibf_b;
   wire obf_n_a;
   wire obf_n_b;
   wire intr_a;
   wire intr_b;
   wire a_hs_in;
   reg [WIDTH-1:0] next_data;
   reg [WIDTH-1:0] next_pc;
   reg [WIDTH-1:0] next_pc_oe;
   reg [WIDTH-1:0] next_pa_oe;
   reg [WIDTH-1:0] next_pa;
   reg [WIDTH-1:0] c_status;

   function [WIDTH-1:0] ppio_fill;
      input bit_v;
      begin
         ppio_fill = {WIDTH{bit_v}};
      end
   endfunction

   // Pin and strobe inputs pass two flops
   ppio_sync #(.WIDTH(WIDTH)) u_sync_a (
      .sys_clk_i(SYS_CLK_I),
      .ce_i(CE_I),
      .async_i(PA_I),
      .sync_o(pa_s)
   );
   ppio_sync #(.WIDTH(WIDTH)) u_sync_b (
      .sys_clk_i(SYS_CLK_I),
      .ce_i(CE_I),
      .async_i(PB_I),
      .sync_o(pb_s)
   );
   ppio_sync #(.WIDTH(WIDTH)) u_sync_c (
      .sys_clk_i(SYS_CLK_I),
      .ce_i(CE_I),
      .async_i(PC_I),
      .sync_o(pc_s)
   );
   ppio_sync #(.WIDTH(3)) u_sync_bus (
      .sys_clk_i(SYS_CLK_I),
      .ce_i(CE_I),
      .async_i({~CS_N_I, ~RD_N_I, ~WR_N_I}),
      .sync_o(strb_s)
   );

   assign cs = strb_s[2];
   assign rd_s = cs & strb_s[1];
   assign wr_s = cs & strb_s[0];
   assign rd_end = rd_d & ~rd_s;
   assign wr_pulse = wr_s & ~wr_d;

   // Two groups, each with its own mode
   assign mode_a = ctl[`PPIO_CTL_AMODE_HI:`PPIO_CTL_AMODE_LO];
   assign mode_b = ctl[`PPIO_CTL_BMODE];
   assign a_in = ctl[`PPIO_CTL_ADIR];
   assign b_in = ctl[`PPIO_CTL_BDIR];
   assign ch_in = ctl[`PPIO_CTL_CHDIR];
   assign cl_in = ctl[`PPIO_CTL_CLDIR];
   assign a_strobe = (mode_a == `PPIO_MODE_STROBE);
   assign a_bidir = mode_a[1];
   assign wr_a = wr_pulse & (ADDR_I == `PPIO_ADR_PA);
   assign wr_b = wr_pulse & (ADDR_I == `PPIO_ADR_PB);
   assign rd_a = rd_end & (ADDR_I == `PPIO_ADR_PA);
   assign rd_b = rd_end & (ADDR_I == `PPIO_ADR_PB);
   // In bidir mode the input side of the first port always runs
   assign a_hs_in = a_bidir | a_in;

   ppio_hs #(.WIDTH(WIDTH)) u_hs_a (
      .sys_clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .active_i(a_strobe | a_bidir),
      .in_dir_i(a_hs_in),
      .inte_i(out_c[`PPIO_PC_STBA] | out_c[`PPIO_PC_ACKA]),
      .stb_n_i(pc_s[`PPIO_PC_STBA]),
      .ack_n_i(pc_s[`PPIO_PC_ACKA]),
      .pins_i(pa_s),
      .cpu_rd_i(rd_a),
      .cpu_wr_i(wr_a),
      .latch_o(lat_a),
      .ibf_o(ibf_a),
      .obf_n_o(obf_n_a),
      .intr_o(intr_a)
   );

   ppio_hs #(.WIDTH(WIDTH)) u_hs_b (
      .sys_clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .active_i(mode_b),
      .in_dir_i(b_in),
      .inte_i(out_c[`PPIO_PC_STBB]),
      .stb_n_i(pc_s[`PPIO_PC_STBB]),
      .ack_n_i(pc_s[`PPIO_PC_STBB]),
      .pins_i(pb_s),
      .cpu_rd_i(rd_b),
      .cpu_wr_i(wr_b),
      .latch_o(lat_b),
      .ibf_o(ibf_b),
      .obf_n_o(obf_n_b),
      .intr_o(intr_b)
   );

   // Third-port view: handshake status replaces reassigned bits
   always @* begin
      c_status = pc_s;
      if (mode_b) begin
         c_status[`PPIO_PC_INTRB] = intr_b;
         c_status[`PPIO_PC_IBFB] = b_in ? ibf_b : obf_n_b;
      end
      if (a_strobe || a_bidir) begin
         c_status[`PPIO_PC_INTRA] = intr_a;
         if (a_hs_in) begin
            c_status[`PPIO_PC_IBFA] = ibf_a;
         end
         if (a_bidir || !a_in) begin
            c_status[`PPIO_PC_OBFA] = obf_n_a;
         end
      end
   end

   // Read mux: basic inputs come from the pin synchronisers only
   always @* begin
      case (ADDR_I)
         `PPIO_ADR_PA: begin
            if (a_bidir || (a_strobe && a_in)) begin
               next_data = lat_a;
            end else if (a_in) begin
               next_data = pa_s;
            end else begin
               next_data = out_a;
            end
         end
         `PPIO_ADR_PB: begin
            if (mode_b && b_in) begin
               next_data = lat_b;
            end else if (b_in) begin
               next_data = pb_s;
            end else begin
               next_data = out_b;
            end
         end
         `PPIO_ADR_PC: next_data = c_status;
         default: next_data = ctl;
      endcase
   end

   // Third-port drive: halves by direction, handshake lines by mode
   always @* begin
      next_pc = out_c;
      next_pc_oe = {{(WIDTH / 2){~ch_in}}, {(WIDTH / 2){~cl_in}}};
      if (mode_b) begin
         next_pc_oe[`PPIO_PC_INTRB] = 1'b1;
         next_pc_oe[`PPIO_PC_IBFB] = 1'b1;
         next_pc_oe[`PPIO_PC_STBB] = 1'b0;
         next_pc[`PPIO_PC_INTRB] = intr_b;
         next_pc[`PPIO_PC_IBFB] = b_in ? ibf_b : obf_n_b;
      end
      if (a_strobe || a_bidir) begin
         next_pc_oe[`PPIO_PC_INTRA] = 1'b1;
         next_pc[`PPIO_PC_INTRA] = intr_a;
         next_pc_oe[`PPIO_PC_STBA] = ~a_hs_in;
         next_pc_oe[`PPIO_PC_IBFA] = a_hs_in;
         next_pc[`PPIO_PC_IBFA] = ibf_a;
         next_pc_oe[`PPIO_PC_ACKA] = ~(a_bidir | ~a_in);
         next_pc_oe[`PPIO_PC_OBFA] = a_bidir | ~a_in;
         next_pc[`PPIO_PC_OBFA] = obf_n_a;
      end
   end

   // First port drive: bidir drives only while acknowledged
   always @* begin
      next_pa = out_a;
      if (a_bidir) begin
         next_pa_oe = ppio_fill(~pc_s[`PPIO_PC_ACKA]);
      end else begin
         next_pa_oe = ppio_fill(~a_in);
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         ctl <= `PPIO_CTL_RESET;
         out_a <= {WIDTH{1'b0}};
         out_b <= {WIDTH{1'b0}};
         out_c <= {WIDTH{1'b0}};
         ctl_sync <= 3'h0;
         rd_d <= 1'b0;
         wr_d <= 1'b0;
         DATA_O <= {WIDTH{1'b0}};
         DATA_OE_O <= 1'b0;
         PA_O <= {WIDTH{1'b0}};
         PA_OE_O <= {WIDTH{1'b0}};
         PB_O <= {WIDTH{1'b0}};
         PB_OE_O <= {WIDTH{1'b0}};
         PC_O <= {WIDTH{1'b0}};
         PC_OE_O <= {WIDTH{1'b0}};
      end else if (CE_I) begin
         rd_d <= rd_s;
         wr_d <= wr_s;
         ctl_sync <= strb_s;
         if (wr_pulse) begin
            case (ADDR_I)
               `PPIO_ADR_PA: out_a <= DATA_I;
               `PPIO_ADR_PB: out_b <= DATA_I;
               `PPIO_ADR_PC: out_c <= DATA_I;
               default: begin
                  if (DATA_I[`PPIO_CTL_FLAG]) begin
                     // New mode word clears outputs
                     ctl <= DATA_I;
                     out_a <= {WIDTH{1'b0}};
                     out_b <= {WIDTH{1'b0}};
                     out_c <= {WIDTH{1'b0}};
                  end else begin
                     out_c[DATA_I[`PPIO_BSR_SEL_HI:`PPIO_BSR_SEL_LO]] <= DATA_I[`PPIO_BSR_VAL];
                  end
               end
            endcase
         end
         DATA_O <= next_data;
         DATA_OE_O <= rd_s;
         PA_O <= next_pa;
         PA_OE_O <= next_pa_oe;
         PB_O <= out_b;
         PB_OE_O <= ppio_fill(~b_in);
         PC_O <= next_pc;
         PC_OE_O <= next_pc_oe;
      end
   end
endmodule
`default_nettype wire

/* File: test/ppio_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ppio_chk #(
   parameter WIDTH = 8
) (
   input wire SYS_CLK_I, // Clock
   input wire RST_N_I, // Reset
   input wire CS_N_I, // Select
   input wire RD_N_I, // Read
   input wire WR_N_I, // Write
   input wire DATA_OE_O, // Bus drive
   input wire [WIDTH-1:0] PA_O, // Port 1
   input wire [WIDTH-1:0] PA_OE_O, // Port 1 enables
   input wire [WIDTH-1:0] PB_O, // Port 2
   input wire [WIDTH-1:0] PB_OE_O, // Port 2 enables
   input wire [WIDTH-1:0] PC_O, // Port 3
   input wire [WIDTH-1:0] PC_OE_O // Port 3 enables
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   a_reset_quiet: assert property (
      $rose(RST_N_I) |-> !DATA_OE_O && PA_OE_O == 8'h00 && PB_OE_O == 8'h00 && PC_OE_O == 8'h00)
      else $error("pins driven after reset");
   a_pa_oe_byte: assert property (PA_OE_O == 8'h00 || PA_OE_O == 8'hFF)
      else $error("port 1 enables split");
   a_pb_oe_byte: assert property (PB_OE_O == 8'h00 || PB_OE_O == 8'hFF)
      else $error("port 2 enables split");
   a_read_answer: assert property ((!CS_N_I && !RD_N_I) [*4] |-> DATA_OE_O)
      else $error("read not answered");
   a_oe_cause: assert property (
      DATA_OE_O |-> !$past(RD_N_I, 2) || !$past(RD_N_I, 3) || !$past(RD_N_I, 4))
      else $error("bus driven without read");
   a_oe_release: assert property (RD_N_I [*5] |-> !DATA_OE_O)
      else $error("bus not released");
   a_pa_take: assert property (!$stable(PA_O) |-> $past(!CS_N_I && !WR_N_I, 2))
      else $error("port 1 changed without write");
   a_pb_take: assert property (!$stable(PB_O) |-> $past(!CS_N_I && !WR_N_I, 2))
      else $error("port 2 changed without write");
   c_read: cover property (DATA_OE_O);
   c_pa_drive: cover property (PA_OE_O == 8'hFF);
   c_ibf: cover property (PC_O[5] && PC_OE_O[5]);
endmodule
bind ppio_top ppio_chk #(.WIDTH(WIDTH)) i_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
   .CS_N_I(CS_N_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I), .DATA_OE_O(DATA_OE_O), .PA_O(PA_O),
   .PA_OE_O(PA_OE_O), .PB_O(PB_O), .PB_OE_O(PB_OE_O), .PC_O(PC_O), .PC_OE_O(PC_OE_O));
`default_nettype wire

/* File: test/ppio_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ppio_host (
   input wire logic clk_i, // System clock
   input wire logic [7:0] data_i, // Read data
   input wire logic data_oe_i, // Device drives bus
   output logic cs_n_o, // Chip select
   output logic rd_n_o, // Read strobe
   output logic wr_n_o, // Write strobe
   output logic [1:0] addr_o, // Register select
   output logic [7:0] data_o // Write data
);
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 2'h0;
      data_o = 8'h00;
   end
   task wr(input [1:0] a, input [7:0] d);
      begin
         cs_n_o <= 1'b0;
         wr_n_o <= 1'b0;
         addr_o <= a;
         data_o <= d;
         repeat (4) @(posedge clk_i);
         cs_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         data_o <= ~d;
         repeat (4) @(posedge clk_i);
      end
   endtask
   task rd(input [1:0] a, output [7:0] d);
      integer n;
      begin
         cs_n_o <= 1'b0;
         rd_n_o <= 1'b0;
         addr_o <= a;
         n = 0;
         d = 8'hXX;
         @(posedge clk_i);
         while (data_oe_i !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (data_oe_i === 1'b1) d = data_i;
         cs_n_o <= 1'b1;
         rd_n_o <= 1'b1;
         repeat (5) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

/* File: test/programmable_parallel_io_ports_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ppio_defines.vh"
module programmable_parallel_io_ports_tb;
   logic clk, rst_n, cs_n, rd_n, wr_n, doe;
   logic [1:0] adr;
   logic [7:0] dbus, dout, pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe, d, r, m, cw;
   logic [7:0] pin [3];
   logic [31:0] seed = 32'hF6945718;
   integer error_cnt = 0, checks_done = 0, cyc = 0, k;
   ppio_top #(.WIDTH(8)) i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CS_N_I(cs_n),
      .RD_N_I(rd_n), .WR_N_I(wr_n), .ADDR_I(adr), .DATA_I(dbus), .DATA_O(dout), .DATA_OE_O(doe),
      .PA_I(pin[0]), .PA_O(pa_o), .PA_OE_O(pa_oe), .PB_I(pin[1]), .PB_O(pb_o), .PB_OE_O(pb_oe),
      .PC_I(pin[2]), .PC_O(pc_o), .PC_OE_O(pc_oe));
   ppio_host i_host (.clk_i(clk), .data_i(dout), .data_oe_i(doe), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .addr_o(adr), .data_o(dbus));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         summarize();
      end
   end
   task rnd8(output [7:0] v);
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         v = seed[7:0];
      end
   endtask
   task chk8(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, error_cnt);
         if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // Write, read back and compare one port against its direction mask
   task port_test(input integer p, input [7:0] msk);
      logic [7:0] v, w, q;
      begin
         rnd8(v);
         rnd8(w);
         pin[p] <= v;
         i_host.wr(p[1:0], w);
         i_host.rd(p[1:0], q);
         chk8((p == 0 ? pa_o : p == 1 ? pb_o : pc_o) & msk, w & msk);
         chk8(p == 0 ? pa_oe : p == 1 ? pb_oe : pc_oe, msk);
         chk8(q & ~msk, v & ~msk);
      end
   endtask
   initial begin
      rst_n = 1'b0;
      pin[0] = 8'h00;
      pin[1] = 8'h00;
      pin[2] = 8'hFF;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk8(pa_oe | pb_oe | pc_oe | {7'h00, doe}, 8'h00);
      for (k = 0; k < 3; k = k + 1) port_test(k, 8'h00);
      $display("reset test done");
      for (k = 0; k < 16; k = k + 1) begin
         cw = {3'h4, k[3], k[2], 1'b0, k[1], k[0]};
         i_host.wr(`PPIO_ADR_CTL, cw);
         port_test(0, {8{~k[3]}});
         port_test(1, {8{~k[1]}});
         port_test(2, {{4{~k[2]}}, {4{~k[0]}}});
      end
      $display("basic test done");
      i_host.wr(`PPIO_ADR_CTL, 8'h80);
      i_host.wr(`PPIO_ADR_PC, 8'h00);
      m = 8'h00;
      for (k = 0; k < 16; k = k + 1) begin
         rnd8(r);
         i_host.wr(`PPIO_ADR_CTL, {4'h0, r[2:0], r[7]});
         m[r[2:0]] = r[7];
         chk8(pc_o, m);
      end
      $display("bit test done");
      pin[2] <= 8'hFF;
      rnd8(r);
      pin[0] <= r;
      i_host.wr(`PPIO_ADR_CTL, 8'hB8);
      i_host.wr(`PPIO_ADR_CTL, 8'h09);
      pin[2][4] <= 1'b0;
      repeat (6) @(posedge clk);
      pin[2][4] <= 1'b1;
      pin[0] <= ~r;
      repeat (6) @(posedge clk);
      chk8({6'h00, pc_o[5], pc_o[3]}, 8'h03);
      i_host.rd(`PPIO_ADR_PA, d);
      chk8(d, r);
      chk8({6'h00, pc_o[5], pc_o[3]}, 8'h00);
      $display("strobe test done");
      i_host.wr(`PPIO_ADR_CTL, 8'hC0);
      rnd8(r);
      i_host.wr(`PPIO_ADR_PA, r);
      chk8(pa_oe, 8'h00);
      pin[2][6] <= 1'b0;
      repeat (6) @(posedge clk);
      chk8(pa_oe, 8'hFF);
      chk8(pa_o, r);
      pin[2][6] <= 1'b1;
      repeat (6) @(posedge clk);
      chk8(pa_oe, 8'h00);
      port_test(1, 8'hFF);
      $display("bidir test done");
      summarize();
   end
endmodule
`default_nettype wire
